// ===== rtl/rx_config_lock.sv
// Receiver control registers, lock indicator and frequency error estimator
//
// The AXI4-Lite interface to the registers is this design's own decision.
`timescale 1ns/1ps
// Operation
// [R01] Lock indicator high for a locked loop when lock detect is enabled
// [R02] Any control word load drops the indicator until lock returns
// [R03] Indicator low while the power amplifier powers up
// [R04] I lagging Q decides a one, I leading Q a zero
// [R05] Decided bit drives data pin, raw or synchroniser-latched
// [R06] Front register bit 7 set bypasses the front amplifier
// [R07] Receive path bits 1:0 pick the pre-filter corner
// [R08] Filter register bit 6 bypasses the channel filter
// [R09] Filter clock divides crystal by divisor, then by four
// [R10] Software keeps divider bit 0 at zero
// [R11] Error result read-only at index 22, control at index 21
// [R12] Output select field routes mixer outputs to test pins
// [R13] Software sets sync clock to sixteen times bit rate
// [R14] Divider restarts when its programmed value changes
module rx_config_lock (
    // Clock, reset, enable
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic ce,
    // AXI4-Lite write
    input wire logic [rx_cfg_pkg::ADDR_W-1:0] awaddr,
    input wire logic awvalid,
    output logic awready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    input wire logic wvalid,
    output logic wready,
    output logic [1:0] bresp,
    output logic bvalid,
    input wire logic bready,
    // AXI4-Lite read
    input wire logic [rx_cfg_pkg::ADDR_W-1:0] araddr,
    input wire logic arvalid,
    output logic arready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    output logic rvalid,
    input wire logic rready,
    // Analog status and demodulator pulses
    input wire logic pll_lock_in,
    input wire logic pa_power_up,
    input wire logic lim_i,
    input wire logic lim_q,
    input wire logic bit_sync_clock,
    input wire logic fee_up,
    input wire logic fee_dn,
    input wire logic rx_mode,
    // Data pin
    input wire logic bidir_data_pin_i,
    output logic bidir_data_pin_o,
    output logic bidir_data_pin_oe,
    // Analog controls and filter clocking
    output rx_cfg_pkg::rx_ctrl_t rx_ctrl,
    output logic filt_clk,
    output logic [rx_cfg_pkg::PHASES-1:0] filt_phase,
    // Status
    output logic lock_indicator,
    output logic irq
);
    // Register storage
    logic [7:0] front_q, rxpath_q, filt_q, div_q, freq_error_control_q, fee_q, sync_q;
    logic [rx_cfg_pkg::IRQ_N-1:0] stat_q, stat_d, mask_q, ev;

    // Index decode, shared by both channels
    function automatic logic idx_hit(input logic [4:0] idx);
        unique case (idx)
            rx_cfg_pkg::IDX_FRONT, rx_cfg_pkg::IDX_RXPATH,
            rx_cfg_pkg::IDX_FILT, rx_cfg_pkg::IDX_DIV,
            rx_cfg_pkg::IDX_FREQ_ERROR_CONTROL, rx_cfg_pkg::IDX_FEE,
            rx_cfg_pkg::IDX_STAT, rx_cfg_pkg::IDX_MASK,
            rx_cfg_pkg::IDX_SYNC: idx_hit = 1'b1;
            default: idx_hit = 1'b0;
        endcase
    endfunction : idx_hit

    // Write channel: address and data taken in either order
    logic aw_full_q, w_full_q;
    logic [4:0] widx_q;
    logic [7:0] wbyte_q;
    logic wlane_q, do_write, wr_ok;

    assign awready = ce && !aw_full_q && !bvalid;
    assign wready = ce && !w_full_q && !bvalid;
    assign do_write = ce && aw_full_q && w_full_q && !bvalid;
    assign wr_ok = idx_hit(widx_q);

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_full_q <= 1'b0;
            w_full_q <= 1'b0;
            widx_q <= 5'h00;
            wbyte_q <= 8'h00;
            wlane_q <= 1'b0;
        end else if (ce) begin
            if (awvalid && awready) begin
                aw_full_q <= 1'b1;
                widx_q <= awaddr[6:2];
            end
            if (wvalid && wready) begin
                w_full_q <= 1'b1;
                wbyte_q <= wdata[7:0];
                wlane_q <= wstrb[0];
            end
            if (do_write) begin
                aw_full_q <= 1'b0;
                w_full_q <= 1'b0;
            end
        end
    end

    // Response held until the master takes it
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            bvalid <= 1'b0;
            bresp <= rx_cfg_pkg::RESP_OK;
        end else if (ce) begin
            if (do_write) begin
                bvalid <= 1'b1;
                bresp <= wr_ok ? rx_cfg_pkg::RESP_OK : rx_cfg_pkg::RESP_ERR;
            end else if (bready) begin
                bvalid <= 1'b0;
            end
        end
    end

    // Per-register write strobes
    logic wen;
    logic [7:0] we;
    assign wen = do_write && wlane_q;
    assign we[0] = wen && (widx_q == rx_cfg_pkg::IDX_FRONT);
    assign we[1] = wen && (widx_q == rx_cfg_pkg::IDX_RXPATH);
    assign we[2] = wen && (widx_q == rx_cfg_pkg::IDX_FILT);
    assign we[3] = wen && (widx_q == rx_cfg_pkg::IDX_DIV);
    assign we[4] = wen && (widx_q == rx_cfg_pkg::IDX_FREQ_ERROR_CONTROL);
    assign we[5] = wen && (widx_q == rx_cfg_pkg::IDX_STAT);
    assign we[6] = wen && (widx_q == rx_cfg_pkg::IDX_MASK);
    assign we[7] = wen && (widx_q == rx_cfg_pkg::IDX_SYNC);

    // Control registers; result index has no store path
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            front_q <= rx_cfg_pkg::REG_RST;
            rxpath_q <= rx_cfg_pkg::REG_RST;
            filt_q <= rx_cfg_pkg::REG_RST;
            div_q <= rx_cfg_pkg::REG_RST;
            freq_error_control_q <= rx_cfg_pkg::REG_RST;
            mask_q <= '0;
            sync_q <= rx_cfg_pkg::REG_RST;
        end else if (ce) begin
            if (we[0]) front_q <= wbyte_q; // [R06]
            if (we[1]) rxpath_q <= wbyte_q; // [R07]
            if (we[2]) filt_q <= wbyte_q; // [R08] [R12]
            if (we[3]) div_q <= wbyte_q; // [R09]
            if (we[4]) freq_error_control_q <= wbyte_q; // [R11]
            if (we[6]) mask_q <= wbyte_q[rx_cfg_pkg::IRQ_N-1:0];
            if (we[7]) sync_q <= wbyte_q;
        end
    end

    // Analog controls straight from their fields
    assign rx_ctrl.amp_bypass = front_q[rx_cfg_pkg::B_AMP_BYP]; // [R06]
    assign rx_ctrl.pf_corner = rxpath_q[1:0]; // [R07]
    assign rx_ctrl.sc_bypass = filt_q[rx_cfg_pkg::B_SC_BYP]; // [R08]
    assign rx_ctrl.mix_to_test = filt_q[3:0] == rx_cfg_pkg::MIX_ROUTE_SEL; // [R12]
    assign rx_ctrl.signal_strength_enable = rxpath_q[rx_cfg_pkg::B_SIGNAL_STRENGTH_ENABLE];

    // Read channel: one cycle to answer
    logic [7:0] rsel;
    logic [4:0] ridx;
    assign ridx = araddr[6:2];
    assign arready = ce && !rvalid;
    always_comb begin
        rsel = 8'h00;
        unique case (ridx)
            rx_cfg_pkg::IDX_FRONT: rsel = front_q;
            rx_cfg_pkg::IDX_RXPATH: rsel = rxpath_q;
            rx_cfg_pkg::IDX_FILT: rsel = filt_q;
            rx_cfg_pkg::IDX_DIV: rsel = div_q;
            rx_cfg_pkg::IDX_FREQ_ERROR_CONTROL: rsel = freq_error_control_q;
            rx_cfg_pkg::IDX_FEE: rsel = fee_q; // [R11]
            rx_cfg_pkg::IDX_STAT: rsel = {5'h00, stat_q};
            rx_cfg_pkg::IDX_MASK: rsel = {5'h00, mask_q};
            rx_cfg_pkg::IDX_SYNC: rsel = sync_q;
            default: rsel = 8'h00;
        endcase
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rvalid <= 1'b0;
            rdata <= 32'h0000_0000;
            rresp <= rx_cfg_pkg::RESP_OK;
        end else if (ce) begin
            if (arvalid && arready) begin
                rvalid <= 1'b1;
                rdata <= {24'h00_0000, rsel};
                rresp <= idx_hit(ridx) ? rx_cfg_pkg::RESP_OK : rx_cfg_pkg::RESP_ERR;
            end else if (rready) begin
                rvalid <= 1'b0;
            end
        end
    end

    // Filter clock; divider lsb is software's to keep at zero
    chan_filter_clkgen u_clkgen (
        .aclk(aclk),
        .aresetn(aresetn),
        .ce(ce),
        .div_val(div_q[4:0]), // [R10]
        .filt_clk(filt_clk),
        .phase(filt_phase)
    );

    // Demodulator and synchroniser
    logic rx_bit, bit_tick;
    fsk_bit_decide u_decide (
        .aclk(aclk),
        .aresetn(aresetn),
        .ce(ce),
        .lim_i(lim_i),
        .lim_q(lim_q),
        .bit_sync_clock(bit_sync_clock),
        .sync_en(sync_q[rx_cfg_pkg::B_SYNC_EN]),
        .rx_bit(rx_bit),
        .bit_tick(bit_tick)
    );

    // Pin driven only in receive; input side unused while receiving
    logic pin_sink;
    assign pin_sink = bidir_data_pin_i;
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            bidir_data_pin_o <= 1'b0;
            bidir_data_pin_oe <= 1'b0;
        end else if (ce) begin
            bidir_data_pin_o <= rx_bit; // [R05]
            bidir_data_pin_oe <= rx_mode;
        end
    end

    // Lock state: a reload or PA power-up forces and restarts the settle window
    rx_cfg_pkg::lock_state_t lk_q, lk_d;
    logic [7:0] hold_q;
    logic lock_detect_enable, reload, hold_done, restart, hold_run;
    assign lock_detect_enable = rxpath_q[rx_cfg_pkg::B_LOCK_DETECT_ENABLE];
    assign reload = do_write && wr_ok;
    assign restart = reload || pa_power_up;
    // Window counts only once the last load or PA start is over
    assign hold_run = lk_d == rx_cfg_pkg::LK_SETTLE && lk_q == lk_d && !restart;
    assign hold_done = hold_q == 8'(rx_cfg_pkg::RELOCK_CYC - 1);

    always_comb begin
        lk_d = lk_q;
        unique case (lk_q)
            rx_cfg_pkg::LK_OFF: lk_d = rx_cfg_pkg::LK_SETTLE;
            rx_cfg_pkg::LK_SETTLE: if (hold_done) lk_d = rx_cfg_pkg::LK_ACQ;
            rx_cfg_pkg::LK_ACQ: if (pll_lock_in) lk_d = rx_cfg_pkg::LK_LOCKED;
            rx_cfg_pkg::LK_LOCKED: if (!pll_lock_in) lk_d = rx_cfg_pkg::LK_ACQ;
        endcase
        if (restart) lk_d = rx_cfg_pkg::LK_SETTLE; // [R02] [R03]
        if (!lock_detect_enable) lk_d = rx_cfg_pkg::LK_OFF; // [R01]
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            lk_q <= rx_cfg_pkg::LK_OFF;
            hold_q <= 8'h00;
            lock_indicator <= 1'b0;
        end else if (ce) begin
            lk_q <= lk_d;
            hold_q <= hold_run ? hold_q + 8'h01 : 8'h00;
            lock_indicator <= lk_d == rx_cfg_pkg::LK_LOCKED; // [R01]
        end
    end

    // Error estimator: net up/down tally over 8<<sel bit periods
    logic [7:0] acc_q, acc_nx;
    logic [6:0] bits_q, bits_last;
    logic fee_en, fee_trig;
    assign fee_en = freq_error_control_q[1:0] == rx_cfg_pkg::FEE_ON; // [R11]
    assign bits_last = 7'(7'h08 << freq_error_control_q[3:2]) - 7'h01;
    assign fee_trig = fee_en && bit_tick && (bits_q == bits_last);
    assign acc_nx = acc_q + {{7{fee_dn && !fee_up}}, fee_up ^ fee_dn};

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            acc_q <= 8'h00;
            bits_q <= 7'h00;
            fee_q <= rx_cfg_pkg::REG_RST;
        end else if (ce) begin
            if (!fee_en) begin
                acc_q <= 8'h00;
                bits_q <= 7'h00;
            end else if (fee_trig) begin
                fee_q <= acc_nx; // [R11]
                acc_q <= 8'h00;
                bits_q <= 7'h00;
            end else begin
                acc_q <= acc_nx;
                bits_q <= bit_tick ? bits_q + 7'h01 : bits_q;
            end
        end
    end

    // Sticky events; a same-cycle set beats the write-one clear
    assign ev[rx_cfg_pkg::EV_LOCK] = ce && !lock_indicator && lk_d == rx_cfg_pkg::LK_LOCKED;
    assign ev[rx_cfg_pkg::EV_UNLOCK] = ce && lock_indicator && lk_d != rx_cfg_pkg::LK_LOCKED;
    assign ev[rx_cfg_pkg::EV_FEE] = ce && fee_trig;
    assign stat_d = (stat_q & ~(we[5] ? wbyte_q[2:0] : 3'h0)) | ev;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            stat_q <= '0;
            irq <= 1'b0;
        end else if (ce) begin
            stat_q <= stat_d;
            irq <= |(stat_d & mask_q);
        end
    end

    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    a_ld_needs_en: assert property (ce && !lock_detect_enable |=> !lock_indicator) // [R01]
        else $error("lock shown while disabled");
    a_ld_follows_pll: assert property ($rose(lock_indicator) |-> $past(pll_lock_in)) // [R01]
        else $error("lock shown without pll lock");
    a_ld_reload_drop: assert property (ce && reload |=> !lock_indicator ##1 !lock_indicator) // [R02]
        else $error("lock not dropped on load");
    a_ld_pa_low: assert property (ce && pa_power_up |=> !lock_indicator) // [R03]
        else $error("lock high during pa power-up");
    a_amp_bypass_wr: assert property (ce && we[0] |=> rx_ctrl.amp_bypass == $past(wbyte_q[7])) // [R06]
        else $error("amp bypass not written");
    a_pf_corner_wr: assert property (ce && we[1] |=> rx_ctrl.pf_corner == $past(wbyte_q[1:0])) // [R07]
        else $error("prefilter corner not written");
    a_sc_bypass_wr: assert property (ce && we[2] |=> rx_ctrl.sc_bypass == $past(wbyte_q[6])) // [R08]
        else $error("filter bypass not written");
    a_fee_transfer: assert property (ce && fee_trig |=> fee_q == $past(acc_nx) && acc_q == 8'h00) // [R11]
        else $error("error result not transferred");
    a_mix_route: assert property (ce && we[2] && wbyte_q[3:0] == rx_cfg_pkg::MIX_ROUTE_SEL |=> rx_ctrl.mix_to_test) // [R12]
        else $error("mixer route not set");
    a_set_wins: assert property (ev[rx_cfg_pkg::EV_FEE] |=> stat_q[rx_cfg_pkg::EV_FEE])
        else $error("event lost against clear");
    c_lock_rise: cover property ($rose(lock_indicator));
    c_fee_trig: cover property (fee_trig);
    c_write_done: cover property (bvalid && bready);
endmodule : rx_config_lock

// ===== rtl/rx_cfg_pkg.sv
// Constants and types for the receiver configuration and lock-detect block
package rx_cfg_pkg;
    // Register indices; byte address is four times the index
    localparam int unsigned ADDR_W = 7;
    localparam logic [4:0] IDX_FRONT = 5'h00;
    localparam logic [4:0] IDX_RXPATH = 5'h01;
    localparam logic [4:0] IDX_FILT = 5'h02;
    localparam logic [4:0] IDX_DIV = 5'h08;
    localparam logic [4:0] IDX_FREQ_ERROR_CONTROL = 5'h15;
    localparam logic [4:0] IDX_FEE = 5'h16;
    localparam logic [4:0] IDX_STAT = 5'h18;
    localparam logic [4:0] IDX_MASK = 5'h19;
    localparam logic [4:0] IDX_SYNC = 5'h1A;
    // Field positions
    localparam int unsigned B_AMP_BYP = 7;
    localparam int unsigned B_LOCK_DETECT_ENABLE = 2;
    localparam int unsigned B_SIGNAL_STRENGTH_ENABLE = 3;
    localparam int unsigned B_SC_BYP = 6;
    localparam int unsigned B_SYNC_EN = 0;
    localparam int unsigned IRQ_N = 3;
    localparam int unsigned EV_LOCK = 0;
    localparam int unsigned EV_UNLOCK = 1;
    localparam int unsigned EV_FEE = 2;
    // Reset values and encodings
    localparam logic [7:0] REG_RST = 8'h00;
    localparam logic [3:0] MIX_ROUTE_SEL = 4'h1;
    localparam logic [1:0] FEE_ON = 2'h3;
    localparam logic [1:0] RESP_OK = 2'h0;
    localparam logic [1:0] RESP_ERR = 2'h2;
    // Timing
    localparam int unsigned CLK_MHZ = 125;
    localparam int unsigned RELOCK_HOLD_NS = 1000;
    localparam int unsigned RELOCK_CYC = (RELOCK_HOLD_NS * CLK_MHZ + 999) / 1000;
    localparam logic [3:0] SYNC_MID = 4'h7;
    localparam int unsigned PHASES = 4;

    typedef enum logic [1:0] {
        LK_OFF = 2'h0,
        LK_SETTLE = 2'h1,
        LK_ACQ = 2'h3,
        LK_LOCKED = 2'h2
    } lock_state_t;

    typedef struct packed {
        logic amp_bypass;
        logic [1:0] pf_corner;
        logic sc_bypass;
        logic mix_to_test;
        logic signal_strength_enable;
    } rx_ctrl_t;
endpackage : rx_cfg_pkg

// ===== rtl/chan_filter_clkgen.sv
// Switched-capacitor filter clock divider and phase generator
`timescale 1ns/1ps
module chan_filter_clkgen (
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic ce,
    // Programmed divider
    input wire logic [4:0] div_val,
    // Divider output pulse and non-overlapping phases
    output logic filt_clk,
    output logic [rx_cfg_pkg::PHASES-1:0] phase
);
    logic [4:0] cnt_q, cnt_d, last_q;
    logic [1:0] ph_q;
    logic changed, wrap;

    // A changed divisor restarts the count so no runt period escapes
    assign changed = div_val != last_q; // [R14]
    assign wrap = (div_val != 5'h00) && (cnt_q >= div_val - 5'h01); // [R09]
    assign cnt_d = (changed || wrap) ? 5'h00 : cnt_q + 5'h01;

    // Count crystal cycles, then step the phase ring every wrap
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            cnt_q <= 5'h00;
            last_q <= 5'h00;
            ph_q <= 2'h0;
            filt_clk <= 1'b0;
            phase <= '0;
        end else if (ce) begin
            last_q <= div_val;
            cnt_q <= cnt_d;
            filt_clk <= wrap && !changed;
            if (wrap && !changed) begin
                ph_q <= ph_q + 2'h1; // [R09]
            end
            phase <= (div_val == 5'h00) ? '0 : 4'h1 << ph_q;
        end
    end

    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    a_div_restart: assert property (ce && changed |=> cnt_q == 5'h00) // [R14]
        else $error("divider did not restart");
    a_div_phase_one: assert property ($onehot0(phase)) // [R09]
        else $error("filter phases overlap");
endmodule : chan_filter_clkgen

// ===== rtl/fsk_bit_decide.sv
// FSK phase decision and bit synchroniser
`timescale 1ns/1ps
module fsk_bit_decide (
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic ce,
    // Limiter outputs and recovery clock
    input wire logic lim_i,
    input wire logic lim_q,
    input wire logic bit_sync_clock,
    input wire logic sync_en,
    // Decided bit and one pulse per bit
    output logic rx_bit,
    output logic bit_tick
);
    logic i_q, bs_q, raw_q, sync_q;
    logic [3:0] ph_q;
    logic i_rise, bs_rise;

    assign i_rise = lim_i && !i_q;
    assign bs_rise = bit_sync_clock && !bs_q;

    // Q already high at an I rise means I lags Q, a one
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            i_q <= 1'b0;
            bs_q <= 1'b0;
            raw_q <= 1'b0;
        end else if (ce) begin
            i_q <= lim_i;
            bs_q <= bit_sync_clock;
            if (i_rise) begin
                raw_q <= lim_q; // [R04]
            end
        end
    end

    // Sixteen sync ticks per bit; edges realign, middle sample latched
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ph_q <= 4'h0;
            sync_q <= 1'b0;
            bit_tick <= 1'b0;
            rx_bit <= 1'b0;
        end else if (ce) begin
            bit_tick <= 1'b0;
            if (i_rise && (lim_q != raw_q)) begin
                ph_q <= 4'h0;
            end else if (bs_rise) begin
                ph_q <= ph_q + 4'h1; // [R13]
                if (ph_q == rx_cfg_pkg::SYNC_MID) begin
                    sync_q <= raw_q;
                    bit_tick <= 1'b1;
                end
            end
            rx_bit <= sync_en ? sync_q : raw_q; // [R05]
        end
    end

    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    a_bit_decide: assert property (ce && i_rise |=> raw_q == $past(lim_q)) // [R04]
        else $error("bit decision wrong");
    a_raw_passed: assert property (ce && !sync_en |=> rx_bit == $past(raw_q)) // [R05]
        else $error("raw bit not on pin");
endmodule : fsk_bit_decide

// ===== verification/rf_front_model.sv
// Limiter and loop lock model standing in for the analog receive chain
`timescale 1ns/1ps
module rf_front_model #(
    parameter int LOCK_DLY = 4
) (
    // Clock
    input wire logic aclk,
    // Wanted bit and loop lock request
    input wire logic bit_val,
    input wire logic lock_req,
    // Limiter levels and loop lock level
    output logic lim_i,
    output logic lim_q,
    output logic pll_lock_in
);
    logic [2:0] ph_q = 3'h0;
    logic [LOCK_DLY-1:0] lk_q = '0;
    initial begin
        lim_i = 1'h0;
        lim_q = 1'h0;
        pll_lock_in = 1'h0;
    end
    // Tone of eight cycles; lock answers slowly, after a few cycles
    always @(posedge aclk) begin
        ph_q <= ph_q + 3'h1;
        lim_i <= ph_q < 3'h4;
        lim_q <= bit_val ? 3'(ph_q + 3'h2) < 3'h4 : 3'(ph_q + 3'h6) < 3'h4;
        lk_q <= {lk_q[LOCK_DLY-2:0], lock_req};
        pll_lock_in <= lk_q[LOCK_DLY-1];
    end
endmodule : rf_front_model

// ===== verification/rx_config_lock_tb.sv
// Self-checking bench for receiver registers, lock indicator and demodulator
`timescale 1ns/1ps
module rx_config_lock_tb;
    localparam logic [1:0] OK = rx_cfg_pkg::RESP_OK;
    localparam int RC = rx_cfg_pkg::RELOCK_CYC;
    logic aclk = 1'h0, aresetn = 1'h0, ce = 1'h1;
    logic [6:0] awaddr = 7'h00, araddr = 7'h00;
    logic [31:0] wdata = 32'h0;
    logic [3:0] wstrb = 4'hF;
    logic awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0, arvalid = 1'h0, rready = 1'h0;
    logic pa_power_up = 1'h0, bit_sync_clock = 1'h0, fee_up = 1'h0, fee_dn = 1'h0;
    logic rx_mode = 1'h0, bidir_data_pin_i = 1'h0, bit_val = 1'h0, lock_req = 1'h0;
    logic awready, wready, bvalid, arready, rvalid, pll_lock_in, lim_i, lim_q;
    logic bidir_data_pin_o, bidir_data_pin_oe, filt_clk, lock_indicator, irq;
    logic [1:0] bresp, rresp;
    logic [31:0] rdata;
    logic [3:0] filt_phase;
    rx_cfg_pkg::rx_ctrl_t rx_ctrl;
    logic [2:0] sc_q = 3'h0;
    logic [4:0] rw[5] = '{5'h00, 5'h01, 5'h02, 5'h08, 5'h15};
    logic [7:0] v[5];
    int failures = 0;
    int checks = 0;

    rx_config_lock i_rx_config_lock (
        .aclk, .aresetn, .ce, .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid,
        .wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp,
        .rvalid, .rready, .pll_lock_in, .pa_power_up, .lim_i, .lim_q, .bit_sync_clock,
        .fee_up, .fee_dn, .rx_mode, .bidir_data_pin_i, .bidir_data_pin_o,
        .bidir_data_pin_oe, .rx_ctrl, .filt_clk, .filt_phase, .lock_indicator, .irq
    );
    rf_front_model i_rf_front_model (.aclk, .bit_val, .lock_req, .lim_i, .lim_q, .pll_lock_in);

    // 125 MHz clock
    always #4 aclk = ~aclk;
    // Sync clock of eight cycles, so a bit lasts 128 cycles; random estimator pulses
    always @(posedge aclk) begin
        sc_q <= sc_q + 3'h1;
        bit_sync_clock <= sc_q[2];
        fee_up <= ($urandom_range(0, 9) == 0);
        fee_dn <= ($urandom_range(0, 9) == 0);
    end

    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        checks++;
        if (g !== e) begin
            failures++;
            $display("MISMATCH %s expected %h seen %h", nm, e, g);
        end
    endtask : chk

    // Each bus task starts one edge on, so no signal is driven twice in a step
    task automatic wr(input logic [4:0] idx, input logic [7:0] d, input logic [1:0] er);
        @(posedge aclk);
        awaddr <= {idx, 2'h0};
        wdata <= {24'h0, d};
        awvalid <= 1'h1;
        wvalid <= 1'h1;
        bready <= 1'h1;
        do begin
            @(posedge aclk);
            if (awready === 1'h1) awvalid <= 1'h0;
            if (wready === 1'h1) wvalid <= 1'h0;
        end while (bvalid !== 1'h1);
        chk("bresp", 32'(er), 32'(bresp));
        bready <= 1'h0;
    endtask : wr

    task automatic rd(input logic [4:0] idx, input logic [7:0] ed, input logic [1:0] er);
        @(posedge aclk);
        araddr <= {idx, 2'h0};
        arvalid <= 1'h1;
        rready <= 1'h1;
        do begin
            @(posedge aclk);
            if (arready === 1'h1) arvalid <= 1'h0;
        end while (rvalid !== 1'h1);
        chk("rresp", 32'(er), 32'(rresp));
        if (er == OK) chk("rdata", 32'(ed), rdata);
        rready <= 1'h0;
    endtask : rd

    task automatic waitlock(output int n);
        n = 0;
        while (lock_indicator !== 1'h1 && n < 400) begin
            @(posedge aclk);
            n++;
        end
    endtask : waitlock

    // Cycles to the next filter pulse, then the pulse-to-pulse period
    task automatic fper(output int n1, output int n2);
        n1 = 0;
        do begin @(posedge aclk); n1++; end while (filt_clk !== 1'h1 && n1 < 99);
        n2 = 0;
        do begin @(posedge aclk); n2++; end while (filt_clk !== 1'h1 && n2 < 99);
    endtask : fper

    task automatic summarize;
        $display("checks %0d failures %0d", checks, failures);
        if (failures == 0 && checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : summarize

    // Main sequence
    initial begin
        int n, m, p;
        void'($urandom(32'hE79C));
        repeat (20) @(posedge aclk);
        aresetn <= 1'h1;
        foreach (rw[k]) rd(rw[k], 8'h00, OK);
        wr(rx_cfg_pkg::IDX_FEE, 8'hA5, OK);
        rd(rx_cfg_pkg::IDX_FEE, 8'h00, OK);
        rd(5'h03, 8'h00, rx_cfg_pkg::RESP_ERR);
        foreach (rw[k]) begin
            v[k] = 8'($urandom);
            if (k == 3) v[k][1:0] = 2'h0;
            if (k == 2) v[k][3:0] = rx_cfg_pkg::MIX_ROUTE_SEL;
            wr(rw[k], v[k], OK);
            rd(rw[k], v[k], OK);
        end
        chk("amp_bypass", 32'(v[0][7]), 32'(rx_ctrl.amp_bypass));
        chk("sc_bypass", 32'(v[2][6]), 32'(rx_ctrl.sc_bypass));
        chk("mix_to_test", 1, 32'(rx_ctrl.mix_to_test));
        chk("signal_strength_enable", 32'(v[1][3]), 32'(rx_ctrl.signal_strength_enable));
        wstrb <= 4'hE;
        wr(rx_cfg_pkg::IDX_FRONT, ~v[0], OK);
        wstrb <= 4'hF;
        rd(rx_cfg_pkg::IDX_FRONT, v[0], OK);
        wr(rx_cfg_pkg::IDX_FILT, 8'h40, OK);
        chk("sc_bypass", 1, 32'(rx_ctrl.sc_bypass));
        chk("mix_to_test", 0, 32'(rx_ctrl.mix_to_test));
        for (int c = 0; c < 4; c++) begin
            wr(rx_cfg_pkg::IDX_RXPATH, 8'(c), OK);
            chk("pf_corner", 32'(c), 32'(rx_ctrl.pf_corner));
        end
        $display("test registers done");
        // Every divisor differs from the last, so a restart fixes the first pulse
        for (int k = 0; k < 5; k++) begin
            m = (k == 0) ? 30 : (k == 1) ? 2 : 4 * k + 2 * $urandom_range(0, 1);
            wr(rx_cfg_pkg::IDX_DIV, 8'(m), OK);
            fper(n, p);
            chk("div_restart", 32'(m + 1), 32'(n));
            chk("div_period", 32'(m), 32'(p));
            chk("phase_onehot", 1, 32'($onehot(filt_phase)));
        end
        // Clock enable low must freeze the phase ring
        ce <= 1'h0;
        @(posedge aclk);
        p = filt_phase;
        repeat (40) @(posedge aclk);
        chk("ce_freeze", 32'(p), 32'(filt_phase));
        ce <= 1'h1;
        $display("test filter clock done");
        lock_req <= 1'h1;
        wr(rx_cfg_pkg::IDX_FREQ_ERROR_CONTROL, 8'h00, OK);
        wr(rx_cfg_pkg::IDX_STAT, 8'h07, OK);
        wr(rx_cfg_pkg::IDX_RXPATH, 8'h04, OK);
        waitlock(n);
        chk("relock_wait", 1, 32'(n >= RC - 4 && n <= RC + 12));
        wr(rx_cfg_pkg::IDX_FRONT, 8'h00, OK);
        chk("lock_drop", 0, 32'(lock_indicator));
        waitlock(n);
        chk("lock_back", 1, 32'(lock_indicator));
        pa_power_up <= 1'h1;
        repeat (3) @(posedge aclk);
        chk("lock_pa", 0, 32'(lock_indicator));
        pa_power_up <= 1'h0;
        waitlock(n);
        chk("lock_pa_back", 1, 32'(lock_indicator));
        // Events are sticky; irq follows only the unmasked ones
        rd(rx_cfg_pkg::IDX_STAT, 8'h03, OK);
        chk("irq", 0, 32'(irq));
        wr(rx_cfg_pkg::IDX_MASK, 8'h01, OK);
        @(posedge aclk); // Interrupt flop follows the new mask one cycle later
        chk("irq", 1, 32'(irq));
        wr(rx_cfg_pkg::IDX_STAT, 8'h01, OK);
        chk("irq", 0, 32'(irq));
        rd(rx_cfg_pkg::IDX_STAT, 8'h02, OK);
        wr(rx_cfg_pkg::IDX_RXPATH, 8'h00, OK);
        repeat (2) @(posedge aclk);
        chk("lock_off", 0, 32'(lock_indicator));
        $display("test lock done");
        // Raw bits settle fast; latched bits get three bit periods
        wr(rx_cfg_pkg::IDX_FREQ_ERROR_CONTROL, 8'h03, OK);
        rx_mode <= 1'h1;
        for (int k = 0; k < 12; k++) begin
            if (k == 8) wr(rx_cfg_pkg::IDX_SYNC, 8'h01, OK);
            bit_val <= 1'($urandom);
            repeat (k < 8 ? 24 : 384) @(posedge aclk);
            chk("data_pin", 32'(bit_val), 32'(bidir_data_pin_o));
            chk("data_oe", 1, 32'(bidir_data_pin_oe));
        end
        rd(rx_cfg_pkg::IDX_STAT, 8'h06, OK);
        $display("test demodulator done");
        summarize();
    end

    // Watchdog well beyond the few thousand cycles the tests need
    initial begin
        repeat (20000) @(posedge aclk);
        failures++;
        summarize();
    end
endmodule : rx_config_lock_tb
